/* src/ccd_readout_sequencer.v */
`timescale 1ns/10ps
`include "ccd_seq_regs.vh"
// Function
// R1 - V1 high pulse moves photodiodes to registers
// R2 - Packet delivered on each H2 falling edge
// R3 - Phase pairs always complementary during transport
// R4 - V2 pulse with A H1 held high
// R5 - Single mode clocks out only A
// R6 - Dual: A low, B high, H2 low
// R7 - Dual: reload A, read both together
// R8 - Binning: two transfers before readout
// R9 - Dump gate pulsed during transfer discards line
// R10 - Reset clock after signal sampled
// R11 - Shutter pulse empties photodiodes, starts exposure
// R12 - Exposure from shutter fall to V1 fall
// R13 - Shutter only in horizontal retrace
// R14 - Retrace index selects exposure length
// R15 - 1024 lines, 1032 pixels per line
// R16 - Progressive single pass per frame
module ccd_readout_sequencer (
	// Clock and reset
	input wire clk_sys,
	input wire srst,
	// Frame control
	input wire frameStart,
	input wire dualLine,
	input wire binTwo,
	input wire [10:0] dumpFirst,
	input wire [10:0] dumpCount,
	input wire shutterEnable,
	input wire [10:0] shutterLine,
	// Sensor clocks
	output reg vert_phase_one_clk,
	output reg vert_phase_two_clk,
	output reg horiz_a_phase_one_clk,
	output reg horiz_b_phase_one_clk,
	output reg horiz_shared_phase_two_clk,
	output reg line_dump_gate,
	output reg shutter_pulse_level,
	output reg resetClkOut,
	// Sampling front end
	output reg sampleA,
	output reg sampleB,
	output reg lineValid,
	output reg darkRow,
	// Status
	output reg frameBusy,
	output reg frameDone
);
	// One-hot states
	localparam [8:0] S_IDLE = 9'h001;
	localparam [8:0] S_PHOTO = 9'h002;
	localparam [8:0] S_VXFER = 9'h004;
	localparam [8:0] S_ATOB = 9'h008;
	localparam [8:0] S_AHIGH = 9'h010;
	localparam [8:0] S_READ = 9'h020;
	localparam [8:0] S_RETRACE = 9'h040;
	localparam [8:0] S_SHUTTER = 9'h080;
	localparam [8:0] S_DONE = 9'h100;

	// Sequencer state
	reg [8:0] state_ff;
	reg [8:0] nxt_state;

	// Frame position counters
	reg [10:0] line_ff;
	reg [1:0] subStep_ff;
	reg [1:0] xferCount_ff;

	// Timer and readout requests
	reg timerLoad;
	reg [7:0] timerValue;
	reg readStart;

	// Frame modes captured at start
	reg modeDual_ff;
	reg modeBin_ff;
	reg shutterArmed_ff;
	reg shutterDone_ff;

	// Step timer and pixel clocker results
	wire timerDone;
	wire readBusy;
	wire hOne;
	wire hTwo;
	wire rClk;
	wire sampStb;
	wire sampDual;

	// Line is within the discard window
	function inDump;
		input [10:0] line;
		input [10:0] first;
		input [10:0] count;
		begin
			inDump = (line >= first) && (line < first + count);
		end
	endfunction

	phase_timer stepTimer (
		.clk_sys(clk_sys),
		.srst(srst),
		.load(timerLoad),
		.loadValue(timerValue),
		.done(timerDone)
	);

	pixel_clocker lineClocker (
		.clk_sys(clk_sys),
		.srst(srst),
		.start(readStart),
		.dualLine(modeDual_ff),
		.hOnePhase(hOne),
		.hTwoPhase(hTwo),
		.resetClk(rClk),
		.sampleStrobe(sampStb),
		.dualSample(sampDual),
		.busy(readBusy)
	);

	// Lines transferred into A before each move to B or readout
	wire [1:0] xferNeeded = modeBin_ff ? 2'h2 : 2'h1;
	// Frame ends once every line has left the vertical registers
	wire lastLine = (line_ff >= `LINES_PER_FRAME);
	// R14 retrace index selects exposure
	wire shutterDue = shutterArmed_ff && !shutterDone_ff && (line_ff >= shutterLine);
	// Current line lies in the discard window
	wire dumpLine = inDump(line_ff, dumpFirst, dumpCount);

	// State sequencing
	always @* begin
		nxt_state = state_ff;
		timerLoad = 1'b0;
		timerValue = `PHASE_TICKS;
		readStart = 1'b0;
		case (state_ff)
			S_IDLE: begin
				if (frameStart) begin
					nxt_state = S_PHOTO;
					timerLoad = 1'b1;
					timerValue = `VPULSE_TICKS;
				end
			end
			S_PHOTO: begin
				if (timerDone) begin
					nxt_state = S_VXFER;
					timerLoad = 1'b1;
					timerValue = `XFER_TICKS;
				end
			end
			S_VXFER: begin
				if (timerDone) begin
					timerLoad = 1'b1;
					if (xferCount_ff + 2'h1 < xferNeeded) begin
						timerValue = `XFER_TICKS;
					end else if (modeDual_ff && subStep_ff == 2'h0) begin
						nxt_state = S_ATOB;
					end else begin
						nxt_state = S_READ;
						readStart = 1'b1;
					end
				end
			end
			S_ATOB: begin
				if (timerDone) begin
					nxt_state = S_AHIGH;
					timerLoad = 1'b1;
				end
			end
			S_AHIGH: begin
				if (timerDone) begin
					nxt_state = S_VXFER;
					timerLoad = 1'b1;
					timerValue = `XFER_TICKS;
				end
			end
			S_READ: begin
				if (!readBusy && !readStart) begin
					nxt_state = S_RETRACE;
					timerLoad = 1'b1;
				end
			end
			S_RETRACE: begin
				if (timerDone) begin
					timerLoad = 1'b1;
					if (shutterDue) begin
						nxt_state = S_SHUTTER;
						timerValue = `SHUTTER_TICKS;
					end else if (lastLine) begin
						nxt_state = S_DONE;
					end else begin
						nxt_state = S_VXFER;
						timerValue = `XFER_TICKS;
					end
				end
			end
			S_SHUTTER: begin
				if (timerDone) begin
					nxt_state = S_RETRACE;
					timerLoad = 1'b1;
				end
			end
			S_DONE: begin
				nxt_state = S_IDLE;
			end
			default: begin
				nxt_state = S_IDLE;
			end
		endcase
	end

	// Counters, mode capture and pin drive
	always @(posedge clk_sys) begin
		if (srst) begin
			state_ff <= S_IDLE;
			line_ff <= 11'h000;
			subStep_ff <= 2'h0;
			xferCount_ff <= 2'h0;
			modeDual_ff <= `MODE_SINGLE;
			modeBin_ff <= 1'b0;
			shutterArmed_ff <= 1'b0;
			shutterDone_ff <= 1'b0;
			vert_phase_one_clk <= 1'b0;
			vert_phase_two_clk <= 1'b1;
			horiz_a_phase_one_clk <= 1'b1;
			horiz_b_phase_one_clk <= 1'b1;
			horiz_shared_phase_two_clk <= 1'b0;
			line_dump_gate <= 1'b0;
			shutter_pulse_level <= 1'b0;
			resetClkOut <= 1'b0;
			sampleA <= 1'b0;
			sampleB <= 1'b0;
			lineValid <= 1'b0;
			darkRow <= 1'b0;
			frameBusy <= 1'b0;
			frameDone <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			frameDone <= 1'b0;
			if (state_ff == S_IDLE && frameStart) begin
				// R16 one pass per frame
				line_ff <= 11'h000;
				subStep_ff <= 2'h0;
				xferCount_ff <= 2'h0;
				modeDual_ff <= dualLine;
				modeBin_ff <= binTwo;
				shutterArmed_ff <= shutterEnable;
				shutterDone_ff <= 1'b0;
				frameBusy <= 1'b1;
			end
			// R1 transfer pulse, R12 fall ends exposure
			vert_phase_one_clk <= (nxt_state == S_PHOTO);
			// R4 V2 pulse into A
			vert_phase_two_clk <= !(nxt_state == S_VXFER && timerValue == `XFER_TICKS
				&& nxt_state != state_ff) && !(state_ff == S_VXFER && !timerDone);
			if (state_ff == S_VXFER && timerDone) begin
				// R8 second transfer before readout
				line_ff <= line_ff + 11'h001;
				if (xferCount_ff + 2'h1 < xferNeeded) begin
					xferCount_ff <= xferCount_ff + 2'h1;
				end else begin
					xferCount_ff <= 2'h0;
					subStep_ff <= (modeDual_ff && subStep_ff == 2'h0) ? 2'h1 : 2'h0;
				end
			end
			// R9 dump during transfer
			line_dump_gate <= (state_ff == S_VXFER) && dumpLine;
			// R6 A low, B high, H2 low
			if (nxt_state == S_ATOB) begin
				horiz_a_phase_one_clk <= 1'b0;
				horiz_b_phase_one_clk <= 1'b1;
				horiz_shared_phase_two_clk <= 1'b0;
			end else if (nxt_state == S_READ && state_ff == S_READ) begin
				// R5 R7 B clocked only in dual
				horiz_a_phase_one_clk <= hOne;
				horiz_b_phase_one_clk <= modeDual_ff ? hOne : 1'b1;
				horiz_shared_phase_two_clk <= hTwo;
			end else begin
				// R7 A back high
				horiz_a_phase_one_clk <= 1'b1;
				horiz_b_phase_one_clk <= 1'b1;
				horiz_shared_phase_two_clk <= 1'b0;
			end
			// Strobes retimed to line up with the phase pins
			resetClkOut <= rClk;
			sampleA <= sampStb;
			sampleB <= sampStb && sampDual;
			lineValid <= readBusy;
			// R15 dark rows at frame end
			darkRow <= readBusy && (line_ff > `LINES_PER_FRAME - `DARK_ROWS);
			// R11 R13 R14 shutter in retrace only
			shutter_pulse_level <= (nxt_state == S_SHUTTER);
			// One shutter per frame
			if (state_ff == S_SHUTTER && timerDone) begin
				shutterDone_ff <= 1'b1;
			end
			// Frame end flag and status
			if (state_ff == S_DONE) begin
				frameBusy <= 1'b0;
				frameDone <= 1'b1;
			end
		end
	end
endmodule // ccd_readout_sequencer

/* src/ccd_seq_regs.vh */
`ifndef CCD_SEQ_REGS_VH
`define CCD_SEQ_REGS_VH

// Frame geometry
`define LINES_PER_FRAME 11'h400
`define PIXELS_PER_LINE 11'h408
`define DARK_COLUMNS 11'h010
`define DARK_ROWS 11'h006
// Phase timing in clk_sys cycles
`define PHASE_TICKS 8'h04
`define VPULSE_TICKS 8'h10
`define XFER_TICKS 8'h40
`define SHUTTER_TICKS 8'h20
// Mode encodings
`define MODE_SINGLE 1'h0
`define MODE_DUAL 1'h1

`endif

/* src/phase_timer.v */
`timescale 1ns/10ps
// Down-counter that flags completion of a timed sequencer step
module phase_timer (
	// Clock and reset
	input wire clk_sys,
	input wire srst,
	// Control
	input wire load,
	input wire [7:0] loadValue,
	// Status
	output wire done
);
	reg [7:0] count_ff;
	reg [7:0] nxt_count;

	// Next count
	always @* begin
		nxt_count = count_ff;
		if (load) begin
			nxt_count = loadValue;
		end else if (count_ff != 8'h00) begin
			nxt_count = count_ff - 8'h01;
		end
	end

	// Count register
	always @(posedge clk_sys) begin
		if (srst) begin
			count_ff <= 8'h00;
		end else begin
			count_ff <= nxt_count;
		end
	end

	assign done = (count_ff == 8'h01); // Last cycle of the step
endmodule // phase_timer

/* src/pixel_clocker.v */
`timescale 1ns/10ps
`include "ccd_seq_regs.vh"
// Runs one line of horizontal pixel clocks, with reset clock per pixel
module pixel_clocker (
	// Clock and reset
	input wire clk_sys,
	input wire srst,
	// Control
	input wire start,
	input wire dualLine,
	// Pins
	output reg hOnePhase,
	output reg hTwoPhase,
	output reg resetClk,
	output reg sampleStrobe,
	output reg dualSample,
	// Status
	output wire busy
);
	reg [10:0] pixelCount_ff;
	reg [1:0] quarter_ff;
	reg active_ff;

	// Four quarters per pixel: H2 falls, sample, reset clock
	always @(posedge clk_sys) begin
		if (srst) begin
			pixelCount_ff <= 11'h000;
			quarter_ff <= 2'h0;
			active_ff <= 1'b0;
			hOnePhase <= 1'b1;
			hTwoPhase <= 1'b0;
			resetClk <= 1'b0;
			sampleStrobe <= 1'b0;
			dualSample <= 1'b0;
		end else begin
			sampleStrobe <= 1'b0;
			resetClk <= 1'b0;
			if (start && !active_ff) begin
				active_ff <= 1'b1;
				pixelCount_ff <= 11'h000;
				quarter_ff <= 2'h0;
				dualSample <= dualLine;
			end else if (active_ff) begin
				quarter_ff <= quarter_ff + 2'h1;
				case (quarter_ff)
					2'h0: begin
						// R3 complementary phases
						hOnePhase <= 1'b0;
						hTwoPhase <= 1'b1;
					end
					2'h1: begin
						// R2 packet on fall
						hOnePhase <= 1'b1;
						hTwoPhase <= 1'b0;
					end
					2'h2: begin
						sampleStrobe <= 1'b1;
					end
					default: begin
						// R10 reset after sample
						resetClk <= 1'b1;
						if (pixelCount_ff == `PIXELS_PER_LINE - 11'h001) begin
							active_ff <= 1'b0;
						end
						pixelCount_ff <= pixelCount_ff + 11'h001;
					end
				endcase
			end
		end
	end

	assign busy = active_ff;
endmodule // pixel_clocker

/* verif/ccd_sensor_model.sv */
`timescale 1ns/10ps
// Sensor model counting packets on the floating node
module ccd_sensor_model (
	// Clock
	input wire logic clk_sys,
	// Sensor clocks
	input wire logic vPhaseTwo,
	input wire logic hPhaseTwo,
	// Packet count
	output logic [10:0] packetCount
);
	logic vPrev_ff = 1'b1;
	logic hPrev_ff = 1'b0;
	initial packetCount = 11'h000;
	always @(posedge clk_sys) begin
		vPrev_ff <= vPhaseTwo;
		hPrev_ff <= hPhaseTwo;
		if (vPrev_ff && !vPhaseTwo)
			packetCount <= 11'h000;
		else if (hPrev_ff && !hPhaseTwo)
			packetCount <= packetCount + 11'h001;
	end
endmodule // ccd_sensor_model

/* verif/ccd_seq_monitor.sv */
`timescale 1ns/10ps
// Pin timing checks on the readout sequencer
module ccd_seq_monitor (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// Control and status
	input wire logic frameStart,
	input wire logic frameBusy,
	input wire logic lineValid,
	// Sensor clocks
	input wire logic vert_phase_one_clk,
	input wire logic vert_phase_two_clk,
	input wire logic horiz_a_phase_one_clk,
	input wire logic horiz_shared_phase_two_clk,
	input wire logic line_dump_gate,
	input wire logic shutter_pulse_level,
	input wire logic resetClkOut,
	input wire logic sampleA
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);

	property p_startAns;
		frameStart && !frameBusy |=> $rose(vert_phase_one_clk);
	endproperty
	a_startAns: assert property (p_startAns) else $error("start gave no transfer pulse");
	property p_v1Len;
		$rose(vert_phase_one_clk) |-> ##15 vert_phase_one_clk ##1 !vert_phase_one_clk;
	endproperty
	a_v1Len: assert property (p_v1Len) else $error("transfer pulse length wrong");
	property p_onePass;
		$rose(vert_phase_one_clk) |-> $rose(frameBusy);
	endproperty
	a_onePass: assert property (p_onePass) else $error("second transfer pulse in frame");
	property p_hComp;
		horiz_shared_phase_two_clk |-> !horiz_a_phase_one_clk;
	endproperty
	a_hComp: assert property (p_hComp) else $error("horizontal phases overlap");
	property p_h2Sample;
		$fell(horiz_shared_phase_two_clk) |-> ##[1:2] sampleA;
	endproperty
	a_h2Sample: assert property (p_h2Sample) else $error("no sample after packet");
	property p_resetAfter;
		sampleA |=> resetClkOut;
	endproperty
	a_resetAfter: assert property (p_resetAfter) else $error("reset clock not after sample");
	property p_v2HoldA;
		!vert_phase_two_clk |-> horiz_a_phase_one_clk;
	endproperty
	a_v2HoldA: assert property (p_v2HoldA) else $error("A phase low during line shift");
	property p_dumpXfer;
		line_dump_gate |-> !lineValid;
	endproperty
	a_dumpXfer: assert property (p_dumpXfer) else $error("dump gate during readout");
	property p_shutRetrace;
		shutter_pulse_level |-> !lineValid;
	endproperty
	a_shutRetrace: assert property (p_shutRetrace) else $error("shutter during readout");
	property p_shutLen;
		$rose(shutter_pulse_level) |-> ##31 shutter_pulse_level ##1 !shutter_pulse_level;
	endproperty
	a_shutLen: assert property (p_shutLen) else $error("shutter length wrong");
	property p_shutV1;
		shutter_pulse_level |-> !vert_phase_one_clk;
	endproperty
	a_shutV1: assert property (p_shutV1) else $error("shutter overlaps transfer pulse");
endmodule // ccd_seq_monitor

bind ccd_readout_sequencer ccd_seq_monitor u_mon (.clk_sys, .srst, .frameStart, .frameBusy,
	.lineValid, .vert_phase_one_clk, .vert_phase_two_clk, .horiz_a_phase_one_clk,
	.horiz_shared_phase_two_clk, .line_dump_gate, .shutter_pulse_level, .resetClkOut, .sampleA);

/* verif/tb_top.sv */
`timescale 1ns/10ps
// Bench for the readout sequencer
module tb_top;
	logic clk_sys = 1'b0, srst = 1'b1, frameStart = 1'b0, dualLine = 1'b0, binTwo = 1'b0;
	logic shutterEnable = 1'b1;
	logic [10:0] dumpFirst = 11'h000, dumpCount = 11'h001, shutterLine = 11'h001;
	wire vOne, vTwo, hOneA, hOneB, hTwo, dumpGate, shutter, rstClk, sampA, sampB;
	wire lineValid, frameBusy, darkRow, frameDone;
	wire [10:0] packetCount;
	int err_total = 0, comparisons = 0, n;
	logic [15:0] cA, cB, cR, cV, cD, cS, cF, cK, cE;
	logic vPrev;

	initial forever #4 clk_sys = ~clk_sys;

	ccd_readout_sequencer DUT (.clk_sys(clk_sys), .srst(srst), .frameStart(frameStart),
		.dualLine(dualLine), .binTwo(binTwo), .dumpFirst(dumpFirst), .dumpCount(dumpCount),
		.shutterEnable(shutterEnable), .shutterLine(shutterLine), .vert_phase_one_clk(vOne),
		.vert_phase_two_clk(vTwo), .horiz_a_phase_one_clk(hOneA), .horiz_b_phase_one_clk(hOneB),
		.horiz_shared_phase_two_clk(hTwo), .line_dump_gate(dumpGate),
		.shutter_pulse_level(shutter), .resetClkOut(rstClk), .sampleA(sampA), .sampleB(sampB),
		.lineValid(lineValid), .darkRow(darkRow), .frameBusy(frameBusy),
		.frameDone(frameDone));
	ccd_sensor_model u_sensor (.clk_sys(clk_sys), .vPhaseTwo(vTwo), .hPhaseTwo(hTwo),
		.packetCount(packetCount));

	task end_sim;
		$display("comparisons=%0d err_total=%0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Counts pin events until lineValid reaches a level
	task run_until(input logic lvl);
		{cA, cB, cR, cV, cD, cS, cF, cK, cE} = '0;
		for (n = 0; n < 5000 && lineValid !== lvl; n++) begin
			vPrev = vTwo;
			@(posedge clk_sys);
			#1;
			cA += sampA; cB += sampB; cR += rstClk; cV += vOne; cD += dumpGate; cS += shutter;
			cF += (vPrev && !vTwo);
			cK += darkRow;
			cE += frameDone;
		end
		if (lineValid !== lvl) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, lineValid, lvl);
			end_sim;
		end
	endtask
	// Mid-run reset with new modes, idle check, then start request raised
	task do_reset(input logic dual, input logic bin, input logic shutEn, input logic [10:0] dCnt);
		@(posedge clk_sys);
		srst <= 1'b1;
		frameStart <= 1'b0;
		dualLine <= dual;
		binTwo <= bin;
		shutterEnable <= shutEn;
		dumpCount <= dCnt;
		repeat (2) @(posedge clk_sys);
		srst <= 1'b0;
		#1;
		chk({vOne, vTwo, hOneA, hOneB, hTwo, dumpGate, shutter, rstClk, sampA, sampB, frameBusy},
			16'h0380);
		repeat (2) begin
			@(posedge clk_sys);
			#1;
			chk({vOne, vTwo, frameBusy, lineValid}, 16'h0004);
		end
		@(posedge clk_sys);
		frameStart <= 1'b1;
	endtask
	// Single mode, first line dumped, start held high while busy
	task t_single;
		@(posedge clk_sys);
		frameStart <= 1'b1;
		run_until(1'b1);
		chk(cV, 16'h0010);
		chk(cD > 0, 16'h0001);
		chk(cS, 16'h0000);
		run_until(1'b0);
		chk(cA, 16'h0408);
		chk(cB, 16'h0000);
		chk(cR, 16'h0408);
		chk(packetCount, 16'h0408);
		chk(cK, 16'h0000);
		chk(cE, 16'h0000);
		chk(frameBusy, 16'h0001);
		run_until(1'b1);
		chk(cS, 16'h0020);
		chk(cV, 16'h0000);
		chk(cD, 16'h0000);
		$display("single line test done");
	endtask
	// Dual mode after a reset in mid-frame, start as a one-cycle pulse
	task t_dual;
		do_reset(1'b1, 1'b0, 1'b0, 11'h000);
		@(posedge clk_sys);
		frameStart <= 1'b0;
		run_until(1'b1);
		chk(cF, 16'h0002);
		chk(cD, 16'h0000);
		run_until(1'b0);
		chk(cA, 16'h0408);
		chk(cB, 16'h0408);
		chk(packetCount, 16'h0408);
		$display("dual line test done");
	endtask
	// Two line transfers before one readout
	task t_bin;
		do_reset(1'b0, 1'b1, 1'b0, 11'h000);
		@(posedge clk_sys);
		frameStart <= 1'b0;
		run_until(1'b1);
		chk(cF, 16'h0002);
		run_until(1'b0);
		chk(cA, 16'h0408);
		chk(cB, 16'h0000);
		chk(packetCount, 16'h0408);
		$display("binning test done");
	endtask

	initial begin
		repeat (2) @(posedge clk_sys);
		srst <= 1'b0;
		t_single;
		t_dual;
		t_bin;
		end_sim;
	end
endmodule // tb_top
